// ---- src/l2c_cfg.sv ----
`timescale 1ns/10ps
`default_nettype none

module l2c_cfg
    import l2c_pkg::*;
#(
    parameter logic [3:0] DTC_DEPTH_EXP = 4'h8,
    parameter logic [7:0] DTC_WAYS = 8'h04,
    parameter logic [3:0] ITC_DEPTH_EXP = 4'h8,
    parameter logic [7:0] ITC_WAYS = 8'h04,
    parameter logic [3:0] PAGE_TABLE_CACHE_A_DEPTH_EXP = 4'h8,
    parameter logic [7:0] PAGE_TABLE_CACHE_A_WAYS = 8'h04,
    parameter logic [3:0] PAGE_TABLE_CACHE_B_DEPTH_EXP = 4'h8,
    parameter logic [7:0] PAGE_TABLE_CACHE_B_WAYS = 8'h04,
    parameter logic [3:0] PDC_DEPTH_EXP = 4'h8,
    parameter logic [7:0] PDC_WAYS = 8'h04
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic index_wr,
    input wire logic [l2c_pkg::IDX_W-1:0] index_wdata,
    input wire logic data_wr,
    input wire logic [31:0] data_wdata,
    output logic [l2c_pkg::IDX_W-1:0] index_rdata,
    output logic [31:0] data_rdata,
    input wire logic xlat_valid,
    input wire logic xlat_in_excl,
    input wire logic xlat_dte_excl,
    input wire logic xlat_dte_tv,
    output logic xlat_abort,
    input wire logic req_valid,
    input wire logic [15:0] req_id,
    output logic [l2c_pkg::IDX_OUT_W-1:0] dtc_set_index,
    output logic [l2c_pkg::IDX_OUT_W-1:0] itc_set_index,
    output logic [l2c_pkg::IDX_OUT_W-1:0] page_table_cache_a_set_index,
    output logic [l2c_pkg::IDX_OUT_W-1:0] page_table_cache_b_set_index,
    output logic [l2c_pkg::IDX_OUT_W-1:0] pdc_set_index,
    output logic [l2c_pkg::PDC_WAYS_MAX-1:0] pdc_way_enable,
    output logic [l2c_pkg::PDC_WAYS_MAX-1:0] pdc_way_access_enable,
    output logic fault_rule_set0_lock,
    output logic fault_rule_set1_lock
);
    import l2c_pkg::*;

    // ==========================================================
    // Indirect index and register storage
    // ==========================================================
    logic [IDX_W-1:0] l2_indirect_index;
    logic [31:0] translation_debug_bits_0;
    logic [31:0] page_dir_cache_way_ctrl;
    logic [31:0] fault_rule_ctrl_set0;
    logic [31:0] fault_rule_ctrl_set1;
    logic [11:0] hash_field [NCACHE];

    wire [3:0] depth_exp [NCACHE];
    wire [7:0] way_count [NCACHE];
    wire [7:0] ctrl_idx [NCACHE];
    assign depth_exp[C_DTC] = DTC_DEPTH_EXP;
    assign depth_exp[C_ITC] = ITC_DEPTH_EXP;
    assign depth_exp[C_PAGE_TABLE_CACHE_A] = PAGE_TABLE_CACHE_A_DEPTH_EXP;
    assign depth_exp[C_PAGE_TABLE_CACHE_B] = PAGE_TABLE_CACHE_B_DEPTH_EXP;
    assign depth_exp[C_PDC] = PDC_DEPTH_EXP;
    assign way_count[C_DTC] = DTC_WAYS;
    assign way_count[C_ITC] = ITC_WAYS;
    assign way_count[C_PAGE_TABLE_CACHE_A] = PAGE_TABLE_CACHE_A_WAYS;
    assign way_count[C_PAGE_TABLE_CACHE_B] = PAGE_TABLE_CACHE_B_WAYS;
    assign way_count[C_PDC] = PDC_WAYS;
    assign ctrl_idx[C_DTC] = IDX_DTC_CTRL;
    assign ctrl_idx[C_ITC] = IDX_ITC_CTRL;
    assign ctrl_idx[C_PAGE_TABLE_CACHE_A] = IDX_PAGE_TABLE_CACHE_A_CTRL;
    assign ctrl_idx[C_PAGE_TABLE_CACHE_B] = IDX_PAGE_TABLE_CACHE_B_CTRL;
    assign ctrl_idx[C_PDC] = IDX_PDC_CTRL;

    wire wr_debug0 = data_wr && (l2_indirect_index == IDX_DEBUG0);
    wire wr_pdc_way = data_wr && (l2_indirect_index == IDX_PDC_WAY);
    wire wr_set0 = data_wr && (l2_indirect_index == IDX_RULE_SET0);
    wire wr_set1 = data_wr && (l2_indirect_index == IDX_RULE_SET1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            l2_indirect_index <= '0;
        end else if (index_wr) begin
            l2_indirect_index <= index_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            translation_debug_bits_0 <= DEBUG0_RST;
            page_dir_cache_way_ctrl <= PDC_WAY_RST;
        end else begin
            if (wr_debug0) begin
                translation_debug_bits_0 <= data_wdata;
            end
            if (wr_pdc_way) begin
                page_dir_cache_way_ctrl <= data_wdata;
            end
        end
    end

    // Once set, a lock holds until reset so a stray write cannot reopen the rule set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_rule_ctrl_set0 <= RULE_RST;
            fault_rule_ctrl_set1 <= RULE_RST;
        end else begin
            if (wr_set0) begin
                fault_rule_ctrl_set0 <= data_wdata | {31'h0, fault_rule_ctrl_set0[LOCK_BIT]};
            end
            if (wr_set1) begin
                fault_rule_ctrl_set1 <= data_wdata | {31'h0, fault_rule_ctrl_set1[LOCK_BIT]};
            end
        end
    end

    assign fault_rule_set0_lock = fault_rule_ctrl_set0[LOCK_BIT];
    assign fault_rule_set1_lock = fault_rule_ctrl_set1[LOCK_BIT];

    // ==========================================================
    // Page-directory way control
    // ==========================================================
    wire [15:0] page_dir_way_off = page_dir_cache_way_ctrl[WAY_OFF_LSB +: 16];
    wire [15:0] page_dir_way_access_off = page_dir_cache_way_ctrl[15:0];
    assign pdc_way_enable = ~page_dir_way_off;
    assign pdc_way_access_enable = ~page_dir_way_access_off;

    // ==========================================================
    // Per-cache control, readback and set index
    // ==========================================================
    logic [IDX_OUT_W-1:0] set_index [NCACHE];
    logic [31:0] ctrl_word [NCACHE];
    logic [NCACHE-1:0] ctrl_hit;

    genvar g;
    generate
        for (g = 0; g < NCACHE; g++) begin : g_cache
            logic [7:0] way_log2;
            logic [3:0] set_bits;
            logic [2:0] func_bits;
            logic [2:0] dev_bits;
            logic [3:0] bus_bits;
            logic [15:0] func_part;
            logic [15:0] dev_part;
            logic [15:0] bus_part;
            logic [15:0] raw_index;
            logic [4:0] dev_shift;
            logic [4:0] bus_shift;

            assign ctrl_hit[g] = (l2_indirect_index == ctrl_idx[g]);
            // Depth exponent and way count are read-only; hash counts are writable
            assign ctrl_word[g] = {depth_exp[g], 4'h0, way_count[g], 4'h0, hash_field[g]};

            always_comb begin
                way_log2 = 8'h00;
                for (int w = 0; w < 8; w++) begin
                    if (way_count[g][w]) begin
                        way_log2 = 8'(w);
                    end
                end
            end
            // Hash counts beyond the set width are clipped, never spilled into the tag
            assign set_bits = depth_exp[g] - way_log2[3:0];

            assign func_bits = hash_field[g][FUNC_LSB +: 3];
            assign dev_bits = hash_field[g][DEV_LSB +: 3];
            assign bus_bits = hash_field[g][BUS_LSB +: 4];
            assign dev_shift = {2'b00, func_bits};
            assign bus_shift = 5'(func_bits) + 5'(dev_bits);
            assign func_part = {13'h0, req_id[2:0]} & ~(16'hffff << func_bits);
            assign dev_part = ({11'h0, req_id[7:3]} & ~(16'hffff << dev_bits)) << dev_shift;
            assign bus_part = ({8'h0, req_id[15:8]} & ~(16'hffff << bus_bits)) << bus_shift;
            assign raw_index = (func_part | dev_part | bus_part) & ~(16'hffff << set_bits);

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    hash_field[g] <= HASH_RST;
                end else if (data_wr && ctrl_hit[g]) begin
                    hash_field[g] <= data_wdata[11:0];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    set_index[g] <= '0;
                end else if (req_valid) begin
                    set_index[g] <= raw_index;
                end
            end
        end
    endgenerate

    assign dtc_set_index = set_index[C_DTC];
    assign itc_set_index = set_index[C_ITC];
    assign page_table_cache_a_set_index = set_index[C_PAGE_TABLE_CACHE_A];
    assign page_table_cache_b_set_index = set_index[C_PAGE_TABLE_CACHE_B];
    assign pdc_set_index = set_index[C_PDC];

    // ==========================================================
    // Exclusion range abort
    // ==========================================================
    wire next_xlat_abort = xlat_valid && xlat_in_excl
        && translation_debug_bits_0[EXCL_ABORT_BIT]
        && !xlat_dte_excl && !xlat_dte_tv;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xlat_abort <= 1'b0;
        end else begin
            xlat_abort <= next_xlat_abort;
        end
    end

    // ==========================================================
    // Read back, unmapped indices read zero
    // ==========================================================
    wire [31:0] rd_ctrl = ctrl_hit[C_DTC] ? ctrl_word[C_DTC]
        : ctrl_hit[C_ITC] ? ctrl_word[C_ITC]
        : ctrl_hit[C_PAGE_TABLE_CACHE_A] ? ctrl_word[C_PAGE_TABLE_CACHE_A]
        : ctrl_hit[C_PAGE_TABLE_CACHE_B] ? ctrl_word[C_PAGE_TABLE_CACHE_B]
        : ctrl_word[C_PDC];
    wire [31:0] next_rdata = (l2_indirect_index == IDX_DEBUG0) ? translation_debug_bits_0
        : (l2_indirect_index == IDX_PDC_WAY) ? page_dir_cache_way_ctrl
        : (l2_indirect_index == IDX_RULE_SET0) ? fault_rule_ctrl_set0
        : (l2_indirect_index == IDX_RULE_SET1) ? fault_rule_ctrl_set1
        : (|ctrl_hit) ? rd_ctrl
        : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_rdata <= 32'h0000_0000;
        end else begin
            data_rdata <= next_rdata;
        end
    end

    assign index_rdata = l2_indirect_index;

endmodule // l2c_cfg

`default_nettype wire

// ---- include/l2c_pkg.sv ----
package l2c_pkg;
    // Indirect index space
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_DEBUG0 = 8'h06;
    localparam logic [7:0] IDX_DTC_CTRL = 8'h10;
    localparam logic [7:0] IDX_ITC_CTRL = 8'h14;
    localparam logic [7:0] IDX_PAGE_TABLE_CACHE_A_CTRL = 8'h18;
    localparam logic [7:0] IDX_PAGE_TABLE_CACHE_B_CTRL = 8'h1c;
    localparam logic [7:0] IDX_RULE_SET1 = 8'h30;
    localparam logic [7:0] IDX_PDC_CTRL = 8'h50;
    localparam logic [7:0] IDX_PDC_WAY = 8'h52;
    localparam logic [7:0] IDX_RULE_SET0 = 8'h80;
    // Field positions
    localparam int EXCL_ABORT_BIT = 8;
    localparam int DEPTH_LSB = 28;
    localparam int WAYS_LSB = 16;
    localparam int FUNC_LSB = 0;
    localparam int DEV_LSB = 4;
    localparam int BUS_LSB = 8;
    localparam int LOCK_BIT = 0;
    localparam int WAY_OFF_LSB = 16;
    // Reset values
    localparam logic [31:0] DEBUG0_RST = 32'h0000_0000;
    localparam logic [31:0] PDC_WAY_RST = 32'h0000_0000;
    localparam logic [31:0] RULE_RST = 32'h0000_0000;
    localparam logic [11:0] HASH_RST = 12'h000;
    // Caches, in generate order
    localparam int NCACHE = 5;
    localparam int C_DTC = 0;
    localparam int C_ITC = 1;
    localparam int C_PAGE_TABLE_CACHE_A = 2;
    localparam int C_PAGE_TABLE_CACHE_B = 3;
    localparam int C_PDC = 4;
    localparam int IDX_OUT_W = 16;
    localparam int PDC_WAYS_MAX = 16;
endpackage

// ---- bench/l2c_cfg_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker
module l2c_cfg_chk
    import l2c_pkg::*;
#(
    parameter logic [3:0] DTC_DEPTH_EXP = 4'h8,
    parameter logic [7:0] DTC_WAYS = 8'h04
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic index_wr,
    input wire logic [l2c_pkg::IDX_W-1:0] index_wdata,
    input wire logic data_wr,
    input wire logic [31:0] data_wdata,
    input wire logic [l2c_pkg::IDX_W-1:0] index_rdata,
    input wire logic [31:0] data_rdata,
    input wire logic xlat_valid,
    input wire logic xlat_in_excl,
    input wire logic xlat_dte_excl,
    input wire logic xlat_dte_tv,
    input wire logic xlat_abort,
    input wire logic req_valid,
    input wire logic [15:0] req_id,
    input wire logic [l2c_pkg::IDX_OUT_W-1:0] dtc_set_index,
    input wire logic [l2c_pkg::IDX_OUT_W-1:0] itc_set_index,
    input wire logic [l2c_pkg::IDX_OUT_W-1:0] page_table_cache_a_set_index,
    input wire logic [l2c_pkg::IDX_OUT_W-1:0] page_table_cache_b_set_index,
    input wire logic [l2c_pkg::IDX_OUT_W-1:0] pdc_set_index,
    input wire logic [l2c_pkg::PDC_WAYS_MAX-1:0] pdc_way_enable,
    input wire logic [l2c_pkg::PDC_WAYS_MAX-1:0] pdc_way_access_enable,
    input wire logic fault_rule_set0_lock,
    input wire logic fault_rule_set1_lock
);
    import l2c_pkg::*;
    // Widest legal set index, from the depth and way parameters
    localparam int SET_BITS = int'(DTC_DEPTH_EXP) - $clog2(DTC_WAYS);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_abort_cause: assert property (xlat_abort |-> $past(xlat_valid && xlat_in_excl))
        else $error("abort without an exclusion request");
    chk_abort_entry: assert property (xlat_abort |-> $past(!xlat_dte_excl && !xlat_dte_tv))
        else $error("abort with entry bits set");
    chk_abort_idle: assert property (!xlat_valid |=> !xlat_abort)
        else $error("abort while idle");
    chk_lock0_sticky: assert property (!$fell(fault_rule_set0_lock))
        else $error("set0 lock cleared");
    chk_lock1_sticky: assert property (fault_rule_set1_lock |=> fault_rule_set1_lock)
        else $error("set1 lock cleared");
    chk_index_hold: assert property (!req_valid |=> $stable({dtc_set_index, itc_set_index,
        page_table_cache_a_set_index, page_table_cache_b_set_index, pdc_set_index})) else $error("set index moved");
    chk_index_width: assert property ((dtc_set_index >> SET_BITS) == '0)
        else $error("set index wider than depth allows");
    chk_way_split: assert property (data_wr && index_rdata == IDX_PDC_WAY |=>
        {pdc_way_enable, pdc_way_access_enable} == ~$past(data_wdata))
        else $error("way enables do not follow way control");
    chk_depth_field: assert property (index_rdata == IDX_DTC_CTRL [*2] |->
        data_rdata[31:28] == DTC_DEPTH_EXP && data_rdata[23:16] == DTC_WAYS)
        else $error("cache size fields wrong");
endmodule // l2c_cfg_chk
`default_nettype wire

// ---- bench/test_l2c_cfg.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_l2c_cfg;
    import l2c_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, index_wr = 1'b0, data_wr = 1'b0, req_valid = 1'b0;
    logic xlat_valid = 1'b0, xlat_in_excl = 1'b0, xlat_dte_excl = 1'b0, xlat_dte_tv = 1'b0;
    logic [7:0] index_wdata = 8'h00, index_rdata;
    logic [31:0] data_wdata = 32'h0, data_rdata, rd_val;
    logic [15:0] req_id = 16'h0, dtc_set_index, itc_set_index, page_table_cache_a_set_index, page_table_cache_b_set_index;
    logic [15:0] pdc_set_index, pdc_way_enable, pdc_way_access_enable;
    logic xlat_abort, fault_rule_set0_lock, fault_rule_set1_lock;
    int miscompares = 0, n_checks = 0;
    logic [7:0] ctrl_idx [5] = '{IDX_DTC_CTRL, IDX_ITC_CTRL, IDX_PAGE_TABLE_CACHE_A_CTRL, IDX_PAGE_TABLE_CACHE_B_CTRL,
        IDX_PDC_CTRL};
    // Interrupt cache gets other sizes so a swapped field shows
    logic [31:0] ctrl_exp [5] = '{32'h8004_0000, 32'h9002_0000, 32'h8004_0000, 32'h8004_0000,
        32'h8004_0000};
    always #25 clk = ~clk;
    l2c_cfg #(.ITC_DEPTH_EXP(4'h9), .ITC_WAYS(8'h02)) u_l2c_cfg (.clk(clk), .rst_n(rst_n),
        .index_wr(index_wr), .index_wdata(index_wdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .index_rdata(index_rdata), .data_rdata(data_rdata),
        .xlat_valid(xlat_valid), .xlat_in_excl(xlat_in_excl), .xlat_dte_excl(xlat_dte_excl),
        .xlat_dte_tv(xlat_dte_tv), .xlat_abort(xlat_abort), .req_valid(req_valid),
        .req_id(req_id), .dtc_set_index(dtc_set_index), .itc_set_index(itc_set_index),
        .page_table_cache_a_set_index(page_table_cache_a_set_index), .page_table_cache_b_set_index(page_table_cache_b_set_index),
        .pdc_set_index(pdc_set_index), .pdc_way_enable(pdc_way_enable),
        .pdc_way_access_enable(pdc_way_access_enable),
        .fault_rule_set0_lock(fault_rule_set0_lock), .fault_rule_set1_lock(fault_rule_set1_lock));
    // ==========================================================
    // Access tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #5;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        index_wr = 1'b1;
        index_wdata = idx;
        tick();
        index_wr = 1'b0;
        data_wr = 1'b1;
        data_wdata = d;
        tick();
        data_wr = 1'b0;
    endtask
    // Read data trails the index by one edge
    task automatic rd(input logic [7:0] idx);
        index_wr = 1'b1;
        index_wdata = idx;
        tick();
        index_wr = 1'b0;
        tick();
        rd_val = data_rdata;
        check("index", {24'h0, index_rdata}, {24'h0, idx});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard: far above the length of the sequence below
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end
    // ==========================================================
    // Sequence
    initial begin
        repeat (10) @(posedge clk);
        #5;
        rst_n = 1'b1;
        tick();
        check("reset way enables", {pdc_way_enable, pdc_way_access_enable}, 32'hffff_ffff);
        check("reset locks", {30'h0, fault_rule_set1_lock, fault_rule_set0_lock}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(ctrl_idx[i], 32'hffff_f000);
            rd(ctrl_idx[i]);
            check("cache size fields", rd_val, ctrl_exp[i]);
        end
        $display("test cache sizes done");
        wr(IDX_DTC_CTRL, 32'h0000_0123);
        rd(IDX_DTC_CTRL);
        check("hash bits", rd_val, 32'h8004_0123);
        // Interrupt cache takes three bus bits, so buses that differ only above bit 2 share sets
        wr(IDX_ITC_CTRL, 32'h0000_0323);
        rd(IDX_ITC_CTRL);
        check("itc hash bits", rd_val, 32'h9002_0323);
        req_id = 16'h05ad;
        req_valid = 1'b1;
        tick();
        req_valid = 1'b0;
        req_id = 16'hffff;
        tick();
        check("set index", {16'h0, dtc_set_index}, 32'h0000_002d);
        check("itc set index", {16'h0, itc_set_index}, 32'h0000_00ad);
        check("ptc set indices", {page_table_cache_a_set_index, page_table_cache_b_set_index}, 32'h0000_0000);
        check("pdc set index", {16'h0, pdc_set_index}, 32'h0000_0000);
        $display("test set index done");
        wr(IDX_PDC_WAY, 32'hf000_0002);
        check("way enables", {pdc_way_enable, pdc_way_access_enable}, 32'h0fff_fffd);
        $display("test way control done");
        wr(IDX_RULE_SET0, 32'h1);
        wr(IDX_RULE_SET1, 32'h1);
        wr(IDX_RULE_SET0, 32'h0);
        wr(IDX_RULE_SET1, 32'h0);
        check("locks", {30'h0, fault_rule_set1_lock, fault_rule_set0_lock}, 32'h3);
        $display("test locks done");
        for (int en = 0; en < 2; en++) begin
            wr(IDX_DEBUG0, (en == 1) ? 32'h0000_0100 : 32'h0);
            for (int k = 0; k < 8; k++) begin
                xlat_valid = 1'b1;
                xlat_in_excl = ~k[2];
                xlat_dte_excl = k[0];
                xlat_dte_tv = k[1];
                tick();
                check("abort", {31'h0, xlat_abort}, {31'h0, en == 1 && k == 0});
            end
            xlat_valid = 1'b0;
            tick();
        end
        $display("test abort done");
        wr(8'h01, 32'hffff_ffff);
        rd(8'h01);
        check("unmapped", rd_val, 32'h0);
        $display("test unmapped done");
        summarize();
    end
endmodule // test_l2c_cfg
bind l2c_cfg l2c_cfg_chk #(.DTC_DEPTH_EXP(DTC_DEPTH_EXP), .DTC_WAYS(DTC_WAYS)) u_l2c_cfg_chk (
    .clk(clk), .rst_n(rst_n), .index_wr(index_wr), .index_wdata(index_wdata),
    .data_wr(data_wr), .data_wdata(data_wdata), .index_rdata(index_rdata),
    .data_rdata(data_rdata), .xlat_valid(xlat_valid), .xlat_in_excl(xlat_in_excl),
    .xlat_dte_excl(xlat_dte_excl), .xlat_dte_tv(xlat_dte_tv), .xlat_abort(xlat_abort),
    .req_valid(req_valid), .req_id(req_id), .dtc_set_index(dtc_set_index),
    .itc_set_index(itc_set_index), .page_table_cache_a_set_index(page_table_cache_a_set_index),
    .page_table_cache_b_set_index(page_table_cache_b_set_index), .pdc_set_index(pdc_set_index),
    .pdc_way_enable(pdc_way_enable), .pdc_way_access_enable(pdc_way_access_enable),
    .fault_rule_set0_lock(fault_rule_set0_lock), .fault_rule_set1_lock(fault_rule_set1_lock));
`default_nettype wire
